// ==== design/adc_conversion_sequencer.sv ====
// Summary of operation
// - main channel starts and stops from the start pin or serial opcodes
// - mode_config_0 bit 6 selects continuous or single-shot operation
// - start and stop opcodes act at the seventh serial clock falling edge
// - bytes 08h and 09h decode as main_start_cmd
// - bytes 0Ah and 0Bh decode as main_stop_cmd
// - bytes 0Ch and 0Dh decode as aux_start_cmd
// - bytes 0Eh and 0Fh decode as aux_stop_cmd
// - single-shot start drives data_ready_low high within two clocks
// - continuous stop lets the running conversion finish, then halts
// - continuous mode runs from start until pin falls or stop opcode
// - pin toggle or stop-start restarts; ready high on restart, low on data
// - single-shot does one conversion per start, then halts
// - single-shot ignores stop opcodes during a running conversion
// - aux channel runs independently from aux start to aux stop opcode
// - input mux write during conversions restarts the conversion
// - only the first conversion has filter latency; later ones nominal rate (with chop or rotation the code repeats base latency plus delay)
// - first latency follows filter order and rate, settling delay included
// - chop or rotation doubles latency plus delay; both quadruple it
// - with chop or rotation, period equals base latency plus delay
// - aux first latency runs from 121 ms slowest to 4.97 ms fastest
// - each start or restart waits 52 us plus programmed delay first (main channel only; aux start loads its first latency at once)
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer #(
   parameter int unsigned TIME_STEP_NS = 10
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic startPin,
   input wire logic chipSelect_b,
   input wire logic serialClk,
   input wire logic serialDin,
   output logic dataReady_b,
   output logic mainRunning,
   output logic auxRunning
);
   // ----------------------------------------
   // types and helpers
   // ----------------------------------------
   typedef enum logic [1:0] {M_IDLE, M_SETTLE, M_CONV} mainState_t;
   typedef enum logic {A_IDLE, A_CONV} auxState_t;

   localparam logic [31:0] STEP = TIME_STEP_NS[31:0];

   function automatic logic opMatch(input logic [6:0] bits, input logic [7:0] op);
      opMatch = (bits == op[7:1]);
   endfunction : opMatch

   function automatic logic addrHit(input logic [7:0] a);
      addrHit = (a == adc_seq_pkg::MODE_CONFIG_0_OFF) || (a == adc_seq_pkg::FILTER_OFF) ||
         (a == adc_seq_pkg::AUXCFG_OFF) || (a == adc_seq_pkg::INMUX_OFF) ||
         (a == adc_seq_pkg::STATUS_OFF);
   endfunction : addrHit

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // 0 start, 1 chip select, 2 serial clock, 3 serial data
   logic [2:0] syncPipe_r [4];
   logic [3:0] pinVal_r;
   logic [3:0] pinPrev_r;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               // idle levels, so no false edge follows reset
               syncPipe_r[gi] <= (gi == 1) ? 3'h7 : 3'h0;
               pinVal_r[gi] <= (gi == 1);
               pinPrev_r[gi] <= (gi == 1);
            end else begin
               syncPipe_r[gi] <= {syncPipe_r[gi][1:0], (gi == 0) ? startPin :
                  (gi == 1) ? chipSelect_b : (gi == 2) ? serialClk : serialDin};
               // only a level seen by both later stages counts
               if (syncPipe_r[gi][1] == syncPipe_r[gi][2]) begin
                  pinVal_r[gi] <= syncPipe_r[gi][2];
               end
               pinPrev_r[gi] <= pinVal_r[gi];
            end
         end
      end
   endgenerate

   logic pinRise;
   logic pinFall;
   logic sclkFall;
   assign pinRise = pinVal_r[0] && !pinPrev_r[0];
   assign pinFall = !pinVal_r[0] && pinPrev_r[0];
   assign sclkFall = pinPrev_r[2] && !pinVal_r[2] && !pinVal_r[1];

   // ----------------------------------------
   // command byte capture
   // ----------------------------------------
   logic [2:0] bitCnt_r;
   logic [5:0] shift_r;
   logic cmdValid;
   logic [6:0] cmdBits;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bitCnt_r <= 3'h0;
         shift_r <= 6'h00;
      end else if (pinVal_r[1]) begin
         bitCnt_r <= 3'h0;
      end else if (sclkFall) begin
         bitCnt_r <= bitCnt_r + 3'h1;
         shift_r <= {shift_r[4:0], pinVal_r[3]};
      end
   end

   // low opcode bit is a don't-care, so decode already at the 7th fall
   assign cmdValid = sclkFall && (bitCnt_r == adc_seq_pkg::OP_DECODE_BIT);
   assign cmdBits = {shift_r, pinVal_r[3]};

   logic mainStartCmd;
   logic mainStopCmd;
   logic auxStartCmd;
   logic auxStopCmd;
   assign mainStartCmd = cmdValid && opMatch(cmdBits, adc_seq_pkg::MAIN_START_OP);
   assign mainStopCmd = cmdValid && opMatch(cmdBits, adc_seq_pkg::MAIN_STOP_OP);
   assign auxStartCmd = cmdValid && opMatch(cmdBits, adc_seq_pkg::AUX_START_OP);
   assign auxStopCmd = cmdValid && opMatch(cmdBits, adc_seq_pkg::AUX_STOP_OP);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [7:0] mode_config_0_r;
   logic [7:0] filter_r;
   logic [1:0] auxCfg_r;
   logic [7:0] inMux_r;
   logic auxReady_r;
   logic apbWrite;
   logic muxWrite;
   logic auxDone;
   mainState_t mainState_r;
   auxState_t auxState_r;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrHit(paddr);
   assign apbWrite = psel && penable && pwrite;
   assign muxWrite = apbWrite && (paddr == adc_seq_pkg::INMUX_OFF);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode_config_0_r <= adc_seq_pkg::MODE_CONFIG_0_RST;
         filter_r <= adc_seq_pkg::FILTER_RST;
         auxCfg_r <= adc_seq_pkg::AUXCFG_RST;
         inMux_r <= adc_seq_pkg::INMUX_RST;
      end else if (apbWrite) begin
         case (paddr)
            adc_seq_pkg::MODE_CONFIG_0_OFF: mode_config_0_r <= pwdata[7:0];
            adc_seq_pkg::FILTER_OFF: filter_r <= pwdata[7:0];
            adc_seq_pkg::AUXCFG_OFF: auxCfg_r <= pwdata[1:0];
            adc_seq_pkg::INMUX_OFF: inMux_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // sticky aux data flag, write one to clear; a new result wins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         auxReady_r <= 1'b0;
      end else if (auxDone) begin
         auxReady_r <= 1'b1;
      end else if (apbWrite && (paddr == adc_seq_pkg::STATUS_OFF) &&
            pwdata[adc_seq_pkg::ST_AUX_RDY]) begin
         auxReady_r <= 1'b0;
      end
   end

   logic [31:0] readMux;
   always_comb begin
      readMux = 32'h0000_0000;
      case (paddr)
         adc_seq_pkg::MODE_CONFIG_0_OFF: readMux[7:0] = mode_config_0_r;
         adc_seq_pkg::FILTER_OFF: readMux[7:0] = filter_r;
         adc_seq_pkg::AUXCFG_OFF: readMux[1:0] = auxCfg_r;
         adc_seq_pkg::INMUX_OFF: readMux[7:0] = inMux_r;
         adc_seq_pkg::STATUS_OFF: begin
            readMux[adc_seq_pkg::ST_MAIN_RUN] = (mainState_r != M_IDLE);
            readMux[adc_seq_pkg::ST_AUX_RUN] = (auxState_r != A_IDLE);
            readMux[adc_seq_pkg::ST_DATA_READY_LOW] = dataReady_b;
            readMux[adc_seq_pkg::ST_AUX_RDY] = auxReady_r;
         end
         default: readMux = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup phase, valid through the access phase
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= readMux;
      end
   end

   // ----------------------------------------
   // latency arithmetic
   // ----------------------------------------
   logic singleShot;
   logic [1:0] rotChop;
   logic [3:0] delayField;
   logic [2:0] filtSel;
   logic [31:0] delayNs;
   logic [31:0] baseNs;
   logic [31:0] firstTotalNs;
   logic [31:0] firstConvNs;
   logic [31:0] nextPeriodNs;
   logic [31:0] periodNs;

   assign singleShot = mode_config_0_r[adc_seq_pkg::CONVERSION_MODE_SELECT_BIT];
   assign rotChop = {mode_config_0_r[adc_seq_pkg::CHOP_BIT], mode_config_0_r[adc_seq_pkg::ROT_BIT]};
   assign delayField = mode_config_0_r[adc_seq_pkg::DELAY_LSB +: 4];
   assign filtSel = filter_r[adc_seq_pkg::FILT_LSB +: 3];
   assign periodNs = adc_seq_pkg::MAIN_PERIOD_NS[filter_r[adc_seq_pkg::RATE_LSB +: 4]];
   // binary steps from 8.7 us; code 0 adds nothing
   assign delayNs = (delayField == 4'h0) ? 32'h0000_0000 :
      (adc_seq_pkg::DELAY_STEP_NS << (delayField - 4'h1));

   always_comb begin
      if (filtSel == adc_seq_pkg::FILT_FIR) begin
         baseNs = adc_seq_pkg::SETTLE_NS + periodNs + adc_seq_pkg::FIR_OVH_NS;
      end else if (filtSel > adc_seq_pkg::FILT_FIR) begin
         baseNs = adc_seq_pkg::SETTLE_NS + periodNs + adc_seq_pkg::SINC_OVH_NS;
      end else begin
         // sinc order n settles after n periods
         baseNs = adc_seq_pkg::SETTLE_NS + adc_seq_pkg::SINC_OVH_NS +
            32'(periodNs * ({29'h0000_0000, filtSel} + 32'h0000_0001));
      end
   end

   always_comb begin
      case (rotChop)
         2'b00: firstTotalNs = baseNs + delayNs;
         2'b11: firstTotalNs = (baseNs + delayNs) << 2;
         default: firstTotalNs = (baseNs + delayNs) << 1;
      endcase
   end

   // settle and programmed delay are timed separately in M_SETTLE
   assign firstConvNs = firstTotalNs - adc_seq_pkg::SETTLE_NS - delayNs;
   assign nextPeriodNs = (rotChop != 2'b00) ? (baseNs + delayNs) : periodNs;

   // ----------------------------------------
   // main channel sequencer
   // ----------------------------------------
   logic [31:0] remNs_r;
   logic haltAfter_r;
   logic mainStartEv;
   logic mainStopEv;
   logic mainRestart;
   logic remDone;
   logic convDone;

   assign mainStartEv = pinRise || mainStartCmd;
   assign mainStopEv = pinFall || mainStopCmd;
   assign mainRestart = mainStartEv || (muxWrite && (mainState_r != M_IDLE));
   assign remDone = (remNs_r <= STEP);
   assign convDone = (mainState_r == M_CONV) && remDone && !mainRestart;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mainState_r <= M_IDLE;
         remNs_r <= 32'h0000_0000;
      end else if (mainRestart) begin
         mainState_r <= M_SETTLE;
         remNs_r <= adc_seq_pkg::SETTLE_NS + delayNs;
      end else begin
         case (mainState_r)
            M_IDLE: remNs_r <= 32'h0000_0000;
            M_SETTLE: begin
               if (remDone) begin
                  mainState_r <= M_CONV;
                  remNs_r <= firstConvNs;
               end else begin
                  remNs_r <= remNs_r - STEP;
               end
            end
            M_CONV: begin
               if (!remDone) begin
                  remNs_r <= remNs_r - STEP;
               end else if (singleShot || haltAfter_r || (mainStopEv && !singleShot)) begin
                  mainState_r <= M_IDLE;
                  remNs_r <= 32'h0000_0000;
               end else begin
                  remNs_r <= nextPeriodNs;
               end
            end
            default: mainState_r <= M_IDLE;
         endcase
      end
   end

   // stop in single-shot is ignored; in continuous the current one finishes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         haltAfter_r <= 1'b0;
      end else if (mainRestart || (mainState_r == M_IDLE)) begin
         haltAfter_r <= 1'b0;
      end else if (mainStopEv && !singleShot) begin
         haltAfter_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // data ready output
   // ----------------------------------------
   logic [3:0] lowCnt_r;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dataReady_b <= 1'b1;
         lowCnt_r <= 4'h0;
      end else if (mainRestart) begin
         dataReady_b <= 1'b1;
         lowCnt_r <= 4'h0;
      end else if (convDone) begin
         dataReady_b <= 1'b0;
         lowCnt_r <= adc_seq_pkg::DATA_READY_LOW_LOW_CYC;
      end else if (lowCnt_r != 4'h0) begin
         lowCnt_r <= lowCnt_r - 4'h1;
         if (lowCnt_r == 4'h1) begin
            dataReady_b <= 1'b1;
         end
      end
   end

   assign mainRunning = (mainState_r != M_IDLE);

   // ----------------------------------------
   // aux channel sequencer
   // ----------------------------------------
   logic [31:0] auxRem_r;
   assign auxDone = (auxState_r == A_CONV) && (auxRem_r <= STEP) && !auxStartCmd && !auxStopCmd;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         auxState_r <= A_IDLE;
         auxRem_r <= 32'h0000_0000;
      end else if (auxStartCmd) begin
         auxState_r <= A_CONV;
         auxRem_r <= adc_seq_pkg::AUX_FIRST_NS[auxCfg_r];
      end else if (auxStopCmd) begin
         auxState_r <= A_IDLE;
         auxRem_r <= 32'h0000_0000;
      end else begin
         case (auxState_r)
            A_IDLE: auxRem_r <= 32'h0000_0000;
            A_CONV: begin
               if (auxDone) begin
                  auxRem_r <= adc_seq_pkg::AUX_PERIOD_NS[auxCfg_r];
               end else begin
                  auxRem_r <= auxRem_r - STEP;
               end
            end
            default: auxState_r <= A_IDLE;
         endcase
      end
   end

   assign auxRunning = (auxState_r != A_IDLE);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_singleDrdyHigh;
      @(posedge mclk) disable iff (!rst_b)
      (singleShot && mainStartEv) |-> ##[1:2] dataReady_b;
   endproperty
   a_singleDrdyHigh: assert property (p_singleDrdyHigh) else $error("ready not high after start");

   property p_singleIgnoresStop;
      @(posedge mclk) disable iff (!rst_b)
      (singleShot && mainStopCmd && !mainStartEv && !muxWrite && mainState_r == M_CONV && !remDone)
         |=> (mainState_r == M_CONV);
   endproperty
   a_singleIgnoresStop: assert property (p_singleIgnoresStop) else $error("stop halted single shot");

   property p_startOpcode;
      @(posedge mclk) disable iff (!rst_b)
      (cmdValid && cmdBits[6:0] == 7'h04) |=> (mainState_r == M_SETTLE) && dataReady_b;
   endproperty
   a_startOpcode: assert property (p_startOpcode) else $error("start opcode not taken");

   property p_stopOpcode;
      @(posedge mclk) disable iff (!rst_b)
      (cmdValid && cmdBits[6:0] == 7'h05 && !singleShot && !pinRise && mainState_r != M_IDLE && !muxWrite)
         |=> haltAfter_r;
   endproperty
   a_stopOpcode: assert property (p_stopOpcode) else $error("stop opcode not taken");

   property p_auxStart;
      @(posedge mclk) disable iff (!rst_b)
      (cmdValid && cmdBits[6:0] == 7'h06) |=> auxRunning && (auxRem_r == $past(adc_seq_pkg::AUX_FIRST_NS[auxCfg_r]));
   endproperty
   a_auxStart: assert property (p_auxStart) else $error("aux start wrong");

   property p_auxStop;
      @(posedge mclk) disable iff (!rst_b)
      (cmdValid && cmdBits[6:0] == 7'h07) |=> !auxRunning;
   endproperty
   a_auxStop: assert property (p_auxStop) else $error("aux stop wrong");

   property p_muxRestart;
      @(posedge mclk) disable iff (!rst_b)
      (muxWrite && mainRunning) |=> (mainState_r == M_SETTLE) && dataReady_b;
   endproperty
   a_muxRestart: assert property (p_muxRestart) else $error("mux write did not restart");

   property p_pinRiseStarts;
      @(posedge mclk) disable iff (!rst_b)
      (syncPipe_r[0][2] && syncPipe_r[0][1] && !pinVal_r[0]) |=> ##1 (mainState_r == M_SETTLE);
   endproperty
   a_pinRiseStarts: assert property (p_pinRiseStarts) else $error("pin rise did not start");

   property p_singleHalts;
      @(posedge mclk) disable iff (!rst_b)
      (singleShot && convDone) |=> (mainState_r == M_IDLE) && !dataReady_b;
   endproperty
   a_singleHalts: assert property (p_singleHalts) else $error("single shot did not halt");

   property p_settleLength;
      @(posedge mclk) disable iff (!rst_b)
      mainRestart |=> (remNs_r == adc_seq_pkg::SETTLE_NS + $past(delayNs));
   endproperty
   a_settleLength: assert property (p_settleLength) else $error("settle time wrong");

   property p_contRuns;
      @(posedge mclk) disable iff (!rst_b)
      (convDone && !singleShot && !haltAfter_r && !mainStopEv) |=> (mainState_r == M_CONV) && !dataReady_b;
   endproperty
   a_contRuns: assert property (p_contRuns) else $error("continuous mode stopped");

   property p_opcodeTiming;
      @(posedge mclk) disable iff (!rst_b)
      cmdValid |=> (bitCnt_r == 3'h7) && !cmdValid;
   endproperty
   a_opcodeTiming: assert property (p_opcodeTiming) else $error("opcode at wrong edge");
endmodule : adc_conversion_sequencer
`default_nettype wire

// ==== design/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;
   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [7:0] MODE_CONFIG_0_OFF = 8'h00;
   localparam logic [7:0] FILTER_OFF = 8'h04;
   localparam logic [7:0] AUXCFG_OFF = 8'h08;
   localparam logic [7:0] INMUX_OFF = 8'h0C;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   // mode_config_0 fields
   localparam int unsigned CONVERSION_MODE_SELECT_BIT = 6;
   localparam int unsigned CHOP_BIT = 5;
   localparam int unsigned ROT_BIT = 4;
   localparam int unsigned DELAY_LSB = 0;
   // filter config fields
   localparam int unsigned FILT_LSB = 5;
   localparam int unsigned RATE_LSB = 0;
   // status fields
   localparam int unsigned ST_MAIN_RUN = 0;
   localparam int unsigned ST_AUX_RUN = 1;
   localparam int unsigned ST_DATA_READY_LOW = 2;
   localparam int unsigned ST_AUX_RDY = 3;
   // reset values
   localparam logic [7:0] MODE_CONFIG_0_RST = 8'h00;
   localparam logic [7:0] FILTER_RST = 8'h00;
   localparam logic [1:0] AUXCFG_RST = 2'h0;
   localparam logic [7:0] INMUX_RST = 8'h01;
   // ----------------------------------------
   // opcodes
   // ----------------------------------------
   localparam logic [7:0] MAIN_START_OP = 8'h08;
   localparam logic [7:0] MAIN_STOP_OP = 8'h0A;
   localparam logic [7:0] AUX_START_OP = 8'h0C;
   localparam logic [7:0] AUX_STOP_OP = 8'h0E;
   localparam logic [2:0] OP_DECODE_BIT = 3'h6;
   // filter codes
   localparam logic [2:0] FILT_FIR = 3'h5;
   // ----------------------------------------
   // times in ns, data ready low time in clocks
   // ----------------------------------------
   localparam logic [31:0] SETTLE_NS = 32'h0000_CB20;
   localparam logic [31:0] SINC_OVH_NS = 32'h0005_4F60;
   localparam logic [31:0] FIR_OVH_NS = 32'h0020_C6A0;
   localparam logic [31:0] DELAY_STEP_NS = 32'h0000_21FC;
   localparam logic [3:0] DATA_READY_LOW_LOW_CYC = 4'h8;
   localparam logic [31:0] MAIN_PERIOD_NS [16] = '{
      32'h17D7_8400, 32'h0BEB_C200, 32'h05F5_E100, 32'h0393_8700,
      32'h02FA_F080, 32'h0131_2D00, 32'h00FE_502B, 32'h0098_9680,
      32'h0026_25A0, 32'h000C_B735, 32'h0006_5B9B, 32'h0003_2DCD,
      32'h0002_1E89, 32'h0001_0F44, 32'h0000_CB73, 32'h0000_65BA};
   localparam logic [31:0] AUX_FIRST_NS [4] = '{
      32'h0736_5040, 32'h01DC_1300, 32'h0084_E770, 32'h004B_D610};
   localparam logic [31:0] AUX_PERIOD_NS [4] = '{
      32'h05F5_E100, 32'h0098_9680, 32'h0026_25A0, 32'h0013_12D0};
endpackage : adc_seq_pkg
`default_nettype wire

// ==== sim/adc_conversion_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
   localparam int unsigned TS = 100000;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, dataReady_b, mainRunning, auxRunning;
   logic startPin, chipSelect_b, serialClk, serialDin, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int errors = 0, n_compared = 0, cyc = 0, t0, lat1, per;
   adc_conversion_sequencer #(.TIME_STEP_NS(TS)) DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .startPin(startPin), .chipSelect_b(chipSelect_b), .serialClk(serialClk),
      .serialDin(serialDin), .dataReady_b(dataReady_b), .mainRunning(mainRunning), .auxRunning(auxRunning));
   host_model host (.mclk(mclk), .startPin(startPin), .chipSelect_b(chipSelect_b), .serialClk(serialClk),
      .serialDin(serialDin));
   // ----------------------------------------
   // clock, timeout, shared tasks
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // tolerance covers pin and serial sync latency
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got, input int tol);
      n_compared++;
      if (got !== exp && (tol == 0 || $isunknown(got) || got > exp + tol || got + tol < exp)) begin
         errors++;
         $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // a fresh falling edge only, never the tail of the last result
   task automatic wait_ready();
      while (dataReady_b !== 1'b1) @(posedge mclk);
      while (dataReady_b !== 1'b0) @(posedge mclk);
   endtask : wait_ready
   task automatic halted(input string nm);
      repeat (12) @(posedge mclk);
      chk(nm, 32'h0000_0000, 32'(mainRunning), 0);
   endtask : halted
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_regs();
      apb(1'b0, adc_seq_pkg::INMUX_OFF, 32'h0000_0000);
      chk("inmux reset", 32'h0000_0001, rd, 0);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, 32'(err), 0);
   endtask : test_regs
   task automatic test_opcodes();
      for (int k = 0; k < 2; k++) begin
         t0 = cyc;
         host.send_cmd(adc_seq_pkg::MAIN_START_OP + 8'(k));
         chk("main run on op", 32'h0000_0001, 32'(mainRunning), 0);
         host.send_cmd(adc_seq_pkg::MAIN_STOP_OP + 8'(k));
         chk("runs past stop", 32'h0000_0001, 32'(mainRunning), 0);
         wait_ready();
         chk("op latency", lat1 + 93, 32'(cyc - t0), 12);
         halted("stop op halts");
         host.send_cmd(adc_seq_pkg::AUX_START_OP + 8'(k));
         chk("aux run", 32'h0000_0001, 32'(auxRunning), 0);
         apb(1'b0, adc_seq_pkg::STATUS_OFF, 32'h0000_0000);
         chk("status", 32'h0000_0006, rd, 0);
         chk("main idle", 32'h0000_0000, 32'(mainRunning), 0);
         host.send_cmd(adc_seq_pkg::AUX_STOP_OP + 8'(k));
         chk("aux stop", 32'h0000_0000, 32'(auxRunning), 0);
      end
   endtask : test_opcodes
   task automatic test_single();
      apb(1'b1, adc_seq_pkg::MODE_CONFIG_0_OFF, 32'h0000_0040);
      apb(1'b1, adc_seq_pkg::FILTER_OFF, 32'h0000_00A0);
      apb(1'b0, adc_seq_pkg::MODE_CONFIG_0_OFF, 32'h0000_0000);
      chk("mode_config_0 readback", 32'h0000_0040, rd, 0);
      t0 = cyc;
      host.pin_level(1'b1);
      chk("ready high", 32'h0000_0001, 32'(dataReady_b), 0);
      chk("pin start", 32'h0000_0001, 32'(mainRunning), 0);
      host.pin_level(1'b0);
      host.send_cmd(adc_seq_pkg::MAIN_STOP_OP);
      wait_ready();
      chk("fir latency", 4027, 32'(cyc - t0), 12);
      halted("single halts");
      apb(1'b1, adc_seq_pkg::FILTER_OFF, 32'h0000_0000);
      apb(1'b1, adc_seq_pkg::MODE_CONFIG_0_OFF, 32'h0000_0000);
   endtask : test_single
   task automatic test_cont();
      host.pin_level(1'b1);
      repeat (2000) @(posedge mclk);
      t0 = cyc;
      apb(1'b1, adc_seq_pkg::INMUX_OFF, 32'h0000_0002);
      wait_ready();
      chk("mux restart", lat1 + 2, 32'(cyc - t0), 12);
      t0 = cyc;
      while (dataReady_b !== 1'b1) @(posedge mclk);
      wait_ready();
      chk("nominal period", per, 32'(cyc - t0), 3);
      repeat (1000) @(posedge mclk);
      t0 = cyc;
      host.pin_level(1'b0);
      host.pin_level(1'b1);
      wait_ready();
      chk("toggle restart", lat1 + 11, 32'(cyc - t0), 12);
      host.pin_level(1'b0);
      chk("finishes", 32'h0000_0001, 32'(mainRunning), 0);
      wait_ready();
      halted("pin stop halts");
   endtask : test_cont
   task automatic test_chop();
      // continuous mode with a brief pulse, never single-shot
      apb(1'b1, adc_seq_pkg::MODE_CONFIG_0_OFF, 32'h0000_0030);
      t0 = cyc;
      host.pin_level(1'b1);
      host.pin_level(1'b0);
      wait_ready();
      chk("chop rot latency", 4 * lat1 + 5, 32'(cyc - t0), 16);
      halted("pulse halts");
   endtask : test_chop
   task automatic test_reset();
      host.send_cmd(adc_seq_pkg::AUX_START_OP);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("aux after reset", 32'h0000_0000, 32'(auxRunning), 0);
      rst_b <= 1'b1;
      apb(1'b0, adc_seq_pkg::MODE_CONFIG_0_OFF, 32'h0000_0000);
      chk("mode_config_0 after reset", 32'h0000_0000, rd, 0);
   endtask : test_reset
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      lat1 = (adc_seq_pkg::SETTLE_NS + adc_seq_pkg::MAIN_PERIOD_NS[0] + adc_seq_pkg::SINC_OVH_NS) / TS;
      per = adc_seq_pkg::MAIN_PERIOD_NS[0] / TS;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      test_regs();
      test_opcodes();
      test_single();
      test_cont();
      test_chop();
      test_reset();
      complete_run();
   end
endmodule : adc_conversion_sequencer_test
`default_nettype wire

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic mclk,
   output logic startPin,
   output logic chipSelect_b,
   output logic serialClk,
   output logic serialDin
);
   // ----------------------------------------
   // start pin and serial command driver
   // ----------------------------------------
   initial begin
      startPin = 1'b0;
      chipSelect_b = 1'b1;
      serialClk = 1'b0;
      serialDin = 1'b0;
   end
   // six clocks each way, above the minimum pulse
   task automatic pin_level(input logic lvl);
      @(posedge mclk);
      startPin <= lvl;
      repeat (6) @(posedge mclk);
   endtask : pin_level
   // clock stays low between frames; data inverted once released
   task automatic send_cmd(input logic [7:0] op);
      #3 chipSelect_b = 1'b0;
      // data moves on the rising edge, so it stands across the falling one
      for (int i = 7; i >= 0; i--) begin
         #62.5 serialClk = 1'b1;
         serialDin = op[i];
         #62.5 serialClk = 1'b0;
      end
      #62.5 chipSelect_b = 1'b1;
      serialDin = ~op[0];
   endtask : send_cmd
endmodule : host_model
`default_nettype wire
